// ---- logic/bl_pwm_pkg.sv ----
// Package with register map, field layout and timing constants of the backlight PWM block.
package bl_pwm_pkg;

    // =========================================================
    // Register map
    // The printed offset is a word index; the byte address is four times the index.
    localparam logic [31:0] PWM_CONTROL_INDEX  = 32'h0000_00AF;
    localparam logic [31:0] PWM_CONTROL_OFFSET = {PWM_CONTROL_INDEX[29:0], 2'h0};

    // =========================================================
    // Field positions of the control register
    localparam int          ENABLE_POS   = 7;
    localparam int          SOURCE_POS   = 6;
    localparam int          DIVIDE_LSB   = 4;
    localparam int          POLARITY_POS = 3;
    localparam int          DUTY_LSB     = 0;

    // =========================================================
    // Reset values
    localparam logic        ENABLE_RESET   = 1'h0;
    localparam logic        SOURCE_RESET   = 1'h1;
    localparam logic [1:0]  DIVIDE_RESET   = 2'h2;
    localparam logic        POLARITY_RESET = 1'h0;
    localparam logic [2:0]  DUTY_RESET     = 3'h4;

    // =========================================================
    // Timing: source rates derived from the 10 MHz system clock
    localparam int          CLOCK_HZ       = 10000000;
    localparam int          FAST_SOURCE_HZ = 24000000;
    localparam int          SLOW_SOURCE_HZ = 32000;
    // The fast source exceeds the system clock, so it runs at the full clock rate.
    localparam int          FAST_DIV_RAW   = CLOCK_HZ / FAST_SOURCE_HZ;
    localparam logic [9:0]  FAST_DIV       = (FAST_DIV_RAW < 1) ? 10'h001 : 10'(FAST_DIV_RAW);
    localparam logic [9:0]  SLOW_DIV       = 10'(CLOCK_HZ / SLOW_SOURCE_HZ);

endpackage

// ---- logic/bl_pwm_divider.sv ----
// Enable pulse divider with a run-time divisor.
`timescale 1ns/100ps
`default_nettype none

module bl_pwm_divider
(
    // Clock and reset
    input  wire logic       clock,
    input  wire logic       resetn,
    // Control
    input  wire logic       run,
    input  wire logic [9:0] divisor,
    // Output
    output logic            tick
);

    logic [9:0] count;

    // =========================================================
    // Counter
    // A divisor change takes effect at once, as the compare uses the live divisor; a count already past it wraps at the next edge.
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            count <= 10'h000;
            tick  <= 1'b0;
        end
        else if (!run)
        begin
            count <= 10'h000;
            tick  <= 1'b0;
        end
        else if (count + 10'h001 >= divisor)
        begin
            count <= 10'h000;
            tick  <= 1'b1;
        end
        else
        begin
            count <= count + 10'h001;
            tick  <= 1'b0;
        end
    end

endmodule
`default_nettype wire

// ---- logic/bl_pwm.sv ----
// Backlight PWM generator with an APB control register and a shared pin takeover.
//
// Decided for this implementation: the register offsets and register access over APB.
`timescale 1ns/100ps
`default_nettype none

module bl_pwm
(
    // Clock and reset
    input  wire logic        CLOCK_IN,
    input  wire logic        RESETN_IN,
    // APB slave
    input  wire logic        PSEL_IN,
    input  wire logic        PENABLE_IN,
    input  wire logic        PWRITE_IN,
    input  wire logic [31:0] PADDR_IN,
    input  wire logic [31:0] PWDATA_IN,
    input  wire logic [3:0]  PSTRB_IN,
    output logic      [31:0] PRDATA_OUT,
    output logic             PREADY_OUT,
    output logic             PSLVERR_OUT,
    // Shared pin, normal function side
    input  wire logic        GPIO_OUT_IN,
    input  wire logic        GPIO_OE_IN,
    // Shared pin
    output logic             PIN_OUT,
    output logic             PIN_OE_OUT
);

    import bl_pwm_pkg::*;

    logic       enable;
    logic       source_slow;
    logic [1:0] divide;
    logic       polarity;
    logic [2:0] duty;
    logic       source_tick;
    logic [2:0] prescale;
    logic       slot_tick;
    logic [2:0] slot;
    logic       wave;
    logic       hit;
    logic       access;
    logic [7:0] control;
    logic [7:0] write_byte;

    // =========================================================
    // APB register
    assign access      = PSEL_IN && PENABLE_IN;
    assign hit         = (PADDR_IN == PWM_CONTROL_OFFSET);
    assign PREADY_OUT  = 1'b1;
    assign PSLVERR_OUT = access && !hit;
    assign control     = {enable, source_slow, divide, polarity, duty};
    assign write_byte  = PWDATA_IN[7:0];

    always_ff @(posedge CLOCK_IN or negedge RESETN_IN)
    begin
        if (!RESETN_IN)
        begin
            enable      <= ENABLE_RESET;
            source_slow <= SOURCE_RESET;
            divide      <= DIVIDE_RESET;
            polarity    <= POLARITY_RESET;
            duty        <= DUTY_RESET;
        end
        else if (access && PWRITE_IN && hit && PSTRB_IN[0])
        begin
            enable      <= PWDATA_IN[ENABLE_POS];
            source_slow <= PWDATA_IN[SOURCE_POS];
            divide      <= PWDATA_IN[DIVIDE_LSB +: 2];
            polarity    <= PWDATA_IN[POLARITY_POS];
            duty        <= PWDATA_IN[DUTY_LSB +: 3];
        end
    end

    // Read data is captured in the setup cycle so it already stands when pready is sampled.
    always_ff @(posedge CLOCK_IN or negedge RESETN_IN)
    begin
        if (!RESETN_IN)
        begin
            PRDATA_OUT <= 32'h0000_0000;
        end
        else if (PSEL_IN && !PENABLE_IN && !PWRITE_IN && hit)
        begin
            PRDATA_OUT <= {24'h00_0000, control};
        end
        else
        begin
            PRDATA_OUT <= 32'h0000_0000;
        end
    end

    // =========================================================
    // Source divider
    // The fast source cannot exceed the system clock, so it ticks every cycle and runs slower than named.
    bl_pwm_divider u_source
    (
        .clock   (CLOCK_IN),
        .resetn  (RESETN_IN),
        .run     (enable),
        .divisor (source_slow ? SLOW_DIV : FAST_DIV),
        .tick    (source_tick)
    );

    // =========================================================
    // Divide by 1, 2, 4 or 8.
    always_ff @(posedge CLOCK_IN or negedge RESETN_IN)
    begin
        if (!RESETN_IN)
        begin
            prescale <= 3'h0;
        end
        else if (!enable)
        begin
            prescale <= 3'h0;
        end
        else if (source_tick)
        begin
            prescale <= prescale + 3'h1;
        end
    end

    always_comb
    begin
        case (divide)
            2'h0:    slot_tick = source_tick;
            2'h1:    slot_tick = source_tick && (prescale[0] == 1'b1);
            2'h2:    slot_tick = source_tick && (prescale[1:0] == 2'h3);
            default: slot_tick = source_tick && (prescale == 3'h7);
        endcase
    end

    // =========================================================
    // Slot counter and waveform
    // Disabling restarts the period so re-enable always begins with the active slots.
    always_ff @(posedge CLOCK_IN or negedge RESETN_IN)
    begin
        if (!RESETN_IN)
        begin
            slot <= 3'h0;
        end
        else if (!enable)
        begin
            slot <= 3'h0;
        end
        else if (slot_tick)
        begin
            slot <= slot + 3'h1;
        end
    end

    always_ff @(posedge CLOCK_IN or negedge RESETN_IN)
    begin
        if (!RESETN_IN)
        begin
            wave <= 1'b0;
        end
        else
        begin
            wave <= (slot < duty) ^ polarity;
        end
    end

    // =========================================================
    // Shared pin takeover
    // The mux is combinational, so the normal function returns in the cycle enable clears.
    assign PIN_OUT    = enable ? wave : GPIO_OUT_IN;
    assign PIN_OE_OUT = enable ? 1'b1 : GPIO_OE_IN;

    // =========================================================
    // Assertions
    property p_pin_owned;
        @(posedge CLOCK_IN) disable iff (!RESETN_IN)
        enable |-> (PIN_OE_OUT && PIN_OUT == wave);
    endproperty
    a_pin_owned: assert property (p_pin_owned) else $error("pin not driven by pwm while enabled");

    property p_pin_released;
        @(posedge CLOCK_IN) disable iff (!RESETN_IN)
        !enable |-> (PIN_OE_OUT == GPIO_OE_IN && PIN_OUT == GPIO_OUT_IN);
    endproperty
    a_pin_released: assert property (p_pin_released) else $error("pin not returned when disabled");

    property p_idle_slot;
        @(posedge CLOCK_IN) disable iff (!RESETN_IN)
        !enable |=> (slot == 3'h0);
    endproperty
    a_idle_slot: assert property (p_idle_slot) else $error("slot runs while disabled");

    property p_wave_level;
        @(posedge CLOCK_IN) disable iff (!RESETN_IN)
        1'b1 |=> (wave == (($past(slot) < $past(duty)) ^ $past(polarity)));
    endproperty
    a_wave_level: assert property (p_wave_level) else $error("wave level wrong for slot");

    property p_zero_duty;
        @(posedge CLOCK_IN) disable iff (!RESETN_IN)
        (duty == 3'h0) ##1 (duty == 3'h0) |-> (wave == $past(polarity));
    endproperty
    a_zero_duty: assert property (p_zero_duty) else $error("zero duty reached active level");

    property p_polarity;
        @(posedge CLOCK_IN) disable iff (!RESETN_IN)
        ($past(RESETN_IN) && $stable(polarity) && $stable(duty) && (duty != 3'h0) && ($past(slot) == 3'h0))
        |-> (wave != polarity);
    endproperty
    a_polarity: assert property (p_polarity) else $error("first slot not active level");

    property p_slot_step;
        @(posedge CLOCK_IN) disable iff (!RESETN_IN)
        (enable && slot_tick) |=> (slot == $past(slot) + 3'h1) || !enable;
    endproperty
    a_slot_step: assert property (p_slot_step) else $error("slot did not advance");

    sequence s_div8_tick;
        enable && !source_slow && (divide == 2'h3) && slot_tick;
    endsequence

    sequence s_div8_hold;
        (enable && !source_slow && (divide == 2'h3))[*7];
    endsequence

    property p_fast_div8;
        @(posedge CLOCK_IN) disable iff (!RESETN_IN)
        s_div8_tick ##1 s_div8_hold |-> !slot_tick;
    endproperty
    a_fast_div8: assert property (p_fast_div8) else $error("divide by eight spacing wrong");

    property p_fast_div1;
        @(posedge CLOCK_IN) disable iff (!RESETN_IN)
        (enable && !source_slow && divide == 2'h0) ##1 (enable && !source_slow && divide == 2'h0) |-> slot_tick;
    endproperty
    a_fast_div1: assert property (p_fast_div1) else $error("fast source not every cycle");

    // =========================================================
    // Assertions on slot timing and the level of trailing slots
    property p_fast_div2;
        @(posedge CLOCK_IN) disable iff (!RESETN_IN)
        (enable && !source_slow && divide == 2'h1 && slot_tick) ##1 (enable && !source_slow && divide == 2'h1)
        |-> !slot_tick;
    endproperty
    a_fast_div2: assert property (p_fast_div2) else $error("divide by two spacing wrong");

    sequence s_div4_tick;
        enable && !source_slow && (divide == 2'h2) && slot_tick;
    endsequence

    sequence s_div4_hold;
        (enable && !source_slow && (divide == 2'h2))[*3];
    endsequence

    property p_fast_div4;
        @(posedge CLOCK_IN) disable iff (!RESETN_IN)
        s_div4_tick ##1 s_div4_hold |-> !slot_tick;
    endproperty
    a_fast_div4: assert property (p_fast_div4) else $error("divide by four spacing wrong");

    property p_slot_hold;
        @(posedge CLOCK_IN) disable iff (!RESETN_IN)
        (enable && !slot_tick) |=> (slot == $past(slot));
    endproperty
    a_slot_hold: assert property (p_slot_hold) else $error("slot moved without a slot tick");

    property p_idle_prescale;
        @(posedge CLOCK_IN) disable iff (!RESETN_IN)
        !enable |=> (prescale == 3'h0);
    endproperty
    a_idle_prescale: assert property (p_idle_prescale) else $error("prescaler runs while disabled");

    property p_trailing_slots;
        @(posedge CLOCK_IN) disable iff (!RESETN_IN)
        ($past(RESETN_IN) && $stable(polarity) && $stable(duty) && ($past(slot) >= duty)) |-> (wave == polarity);
    endproperty
    a_trailing_slots: assert property (p_trailing_slots) else $error("trailing slot not inactive level");

    // =========================================================
    // Assertions on the register bus
    property p_write_lands;
        @(posedge CLOCK_IN) disable iff (!RESETN_IN)
        (access && PWRITE_IN && hit && PSTRB_IN[0]) |=> (control == $past(write_byte));
    endproperty
    a_write_lands: assert property (p_write_lands) else $error("control write did not land");

    property p_write_refused;
        @(posedge CLOCK_IN) disable iff (!RESETN_IN)
        (access && PWRITE_IN && !(hit && PSTRB_IN[0])) |=> $stable(control);
    endproperty
    a_write_refused: assert property (p_write_refused) else $error("refused write changed control");

    property p_read_stands;
        @(posedge CLOCK_IN) disable iff (!RESETN_IN)
        (access && !PWRITE_IN && hit) |-> (PRDATA_OUT == {24'h00_0000, control});
    endproperty
    a_read_stands: assert property (p_read_stands) else $error("read data not standing in access");

endmodule
`default_nettype wire

// ---- tb/bl_driver_model.sv ----
// Model of the external backlight driver that integrates the shared pin.
`timescale 1ns/100ps
`default_nettype none

module bl_driver_model
(
    // Clock and control
    input  wire logic        clock_in,
    input  wire logic        clear_in,
    input  wire logic        active_low_in,
    // Shared pin
    input  wire logic        pin_in,
    input  wire logic        pin_oe_in,
    // Measurements
    output logic      [15:0] active_out,
    output logic      [15:0] rise_out
);
    // =========================================================
    // Integration
    // A pin that is not driven counts as idle, since the driver input only listens while it is driven.
    logic seen;
    logic prev;
    assign seen = pin_oe_in && (pin_in ^ active_low_in);
    always @(posedge clock_in)
    begin
        prev <= seen;
        if (clear_in)
        begin
            active_out <= 16'h0000;
            rise_out   <= 16'h0000;
        end
        else
        begin
            active_out <= active_out + 16'(seen);
            rise_out   <= rise_out + 16'(seen & !prev);
        end
    end
endmodule

`default_nettype wire

// ---- tb/tb_top.sv ----
// Self-checking testbench of the backlight PWM block.
`timescale 1ns/100ps
`default_nettype none

module tb_top;
    import bl_pwm_pkg::*;
    // =========================================================
    // Stimulus and observation
    logic        clock = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic        gpio_out = 0, gpio_oe = 0, clear = 1, act_low = 0;
    logic [31:0] paddr = 0, pwdata = 0, prdata, rd;
    logic [3:0]  pstrb = 4'hF;
    logic        pready, pslverr, pin, pin_oe, err;
    logic [15:0] act_cnt, rise_cnt;
    int          fail_count = 0, cmp_count = 0;

    always #50 clock = ~clock;

    bl_pwm u_dut (.CLOCK_IN(clock), .RESETN_IN(resetn), .PSEL_IN(psel), .PENABLE_IN(penable),
        .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PSTRB_IN(pstrb),
        .PRDATA_OUT(prdata), .PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .GPIO_OUT_IN(gpio_out),
        .GPIO_OE_IN(gpio_oe), .PIN_OUT(pin), .PIN_OE_OUT(pin_oe));
    bl_driver_model u_drv (.clock_in(clock), .clear_in(clear), .active_low_in(act_low),
        .pin_in(pin), .pin_oe_in(pin_oe), .active_out(act_cnt), .rise_out(rise_cnt));

    // =========================================================
    // Shared tasks
    task give_verdict;
        if (fail_count == 0 && cmp_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp)
        begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask

    // Waits for pready with no limit of its own; the watchdog ends a run that hangs here.
    task apb(input logic wr, input logic [31:0] addr, input logic [31:0] wdata);
        int n;
        n = 0;
        @(posedge clock);
        psel <= 1;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= wdata;
        @(posedge clock);
        penable <= 1;
        do
        begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1);
        chk("apb_wait", 1, n);
        rd = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
    endtask

    task measure(input int settle, input int win);
        repeat (settle) @(posedge clock);
        clear <= 1;
        @(posedge clock);
        clear <= 0;
        repeat (win) @(posedge clock);
        #1;
    endtask

    // =========================================================
    // Scenarios
    task t_reset;
        gpio_out <= 1;
        gpio_oe <= 1;
        @(posedge clock);
        #1;
        chk("pin", 1, pin);
        chk("pin_oe", 1, pin_oe);
        apb(0, PWM_CONTROL_OFFSET, 0);
        chk("reset", 32'h64, rd);
    endtask

    task t_refuse;
        apb(1, 32'hB0, 32'hFF);
        chk("wr_err", 1, err);
        apb(0, 32'hB0, 0);
        chk("rd_err", 1, err);
        chk("rd_zero", 0, rd);
        pstrb <= 0;
        apb(1, PWM_CONTROL_OFFSET, 32'hFF);
        pstrb <= 4'hF;
        apb(0, PWM_CONTROL_OFFSET, 0);
        chk("kept", 32'h64, rd);
    endtask

    // A whole number of periods makes both counts exact whatever the phase.
    task t_fast;
        logic [31:0] v;
        for (int p = 0; p < 2; p++)
            for (int d = 0; d < 4; d++)
                for (int n = 0; n < 8; n++)
                begin
                    v = {24'h0, 1'b1, 1'b0, 2'(d), 1'(p), 3'(n)};
                    act_low <= 1'(p);
                    apb(1, PWM_CONTROL_OFFSET, v);
                    apb(0, PWM_CONTROL_OFFSET, 0);
                    chk("ctl", v, rd);
                    chk("oe_on", 1, pin_oe);
                    measure(130, 512);
                    chk("active", 32'(n * 64), 32'(act_cnt));
                    chk("periods", (n == 0) ? 0 : 32'(64 >> d), 32'(rise_cnt));
                end
    endtask

    task t_slow;
        act_low <= 0;
        apb(1, PWM_CONTROL_OFFSET, 32'hC3);
        measure(2600, 4992);
        chk("slow_active", 1872, 32'(act_cnt));
        chk("slow_periods", 2, 32'(rise_cnt));
    endtask

    task t_disable;
        @(posedge clock);
        gpio_out <= 0;
        gpio_oe <= 0;
        apb(1, PWM_CONTROL_OFFSET, 32'h64);
        @(posedge clock);
        #1;
        chk("pin_off", 0, pin);
        chk("oe_off", 0, pin_oe);
    endtask

    // =========================================================
    // Main sequence and watchdog
    initial
    begin
        repeat (5) @(posedge clock);
        resetn <= 1;
        @(posedge clock);
        t_reset;
        t_refuse;
        t_fast;
        t_slow;
        t_disable;
        give_verdict;
    end

    initial
    begin
        repeat (90000) @(posedge clock);
        fail_count++;
        give_verdict;
    end
endmodule

`default_nettype wire
